// ---- bts_pkg.sv ----
// Purpose: shared constants and types of the brake test status block
// Assumes: 20 MHz clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
package bts_pkg;

  // clock and timing
  localparam int CLK_HZ           = 20_000_000;
  localparam int CYC_PER_US       = CLK_HZ / 1_000_000;
  localparam int STEP_TIMEOUT_US  = 1000;
  localparam int STEP_TIMEOUT_CYC = STEP_TIMEOUT_US * CYC_PER_US;
  localparam int HOLD_TIME_US     = 100;
  localparam int HOLD_CYC         = HOLD_TIME_US * CYC_PER_US;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ACCEL  = 8'h0c;
  localparam logic [7:0] OFF_ISTAT  = 8'h10;
  localparam logic [7:0] OFF_IMASK  = 8'h14;

  // control word fields
  localparam int CTL_SUP_EN  = 0;
  localparam int CTL_CFG_OK  = 1;
  localparam int CTL_ATT_LSB = 4;
  // command word fields
  localparam int CMD_TRIG  = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_ACK   = 2;
  // status word fields
  localparam int STS_SUP      = 0;
  localparam int STS_ACK      = 1;
  localparam int STS_PROG_LSB = 4;
  localparam int STS_ERR_LSB  = 8;
  localparam int STS_FAIL_LSB = 16;
  // accel word fields
  localparam int AR_ACT_LSB = 0;
  localparam int AR_ST_LSB  = 16;
  // interrupt bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_SUP    = 2;
  localparam int IRQ_ARFLT  = 3;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0]  MASK_RST = 4'h0;

  // accel range supervisor state codes
  localparam logic [1:0] AR_NOT_RUN = 2'h0;
  localparam logic [1:0] AR_MONITOR = 2'h1;
  localparam logic [1:0] AR_FAULT   = 2'h2;

  // brake test error codes
  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_START   = 8'h01;
  localparam logic [7:0] ERR_NOT_REL = 8'h02;
  localparam logic [7:0] ERR_APPLY   = 8'h03;
  localparam logic [7:0] ERR_RELEASE = 8'h04;
  localparam logic [7:0] ERR_CURRENT = 8'h05;
  localparam logic [7:0] ERR_MOTION  = 8'h06;
  localparam logic [7:0] ERR_CUR_FB  = 8'h07;
  localparam logic [7:0] ERR_COMM    = 8'h08;
  localparam logic [7:0] ERR_TIMEOUT = 8'h09;
  localparam logic [7:0] ERR_SYSTEM  = 8'h0a;
  localparam logic [7:0] ERR_USER    = 8'h0b;
  localparam logic [7:0] ERR_LOAD    = 8'h0c;
  localparam logic [7:0] ERR_UNKNOWN = 8'hff;

  // brake test progress
  typedef enum logic [2:0] {
    BTS_IDLE     = 3'b000,
    BTS_STARTING = 3'b001,
    BTS_STARTED  = 3'b010,
    BTS_TESTING  = 3'b011,
    BTS_STOPPING = 3'b100
  } bts_state_t;

  // per-brake phase
  typedef enum logic [1:0] {
    BTS_PH_APPLY   = 2'b00,
    BTS_PH_HOLD    = 2'b01,
    BTS_PH_RELEASE = 2'b10
  } bts_phase_t;

endpackage

// ---- bts_top.sv ----
// Purpose: brake supervision, brake test sequencer and supervisor status
// Assumes: all inputs synchronous to clk; two brakes at most
// Notes:   APB slave answers without wait states, pslverr on unmapped
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module bts_top import bts_pkg::*; #(
  parameter int NAR         = 3,
  parameter int NB          = 2,
  parameter int TIMEOUT_CYC = STEP_TIMEOUT_CYC
) (
  input  logic             clk,
  input  logic             rst,
  input  logic [7:0]       paddr,
  input  logic             psel,
  input  logic             penable,
  input  logic             pwrite,
  input  logic [31:0]      pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  logic [NAR-1:0]   ar_active_in,
  input  logic [2*NAR-1:0] ar_state_in,
  input  logic             axis_enabled,
  input  logic             axis_standstill,
  input  logic             stop_func_active,
  input  logic [NB-1:0]    brake_release_req,
  input  logic [NB-1:0]    brake_released_fb,
  input  logic             drive_current_ok,
  input  logic             motion_limit_hit,
  input  logic             current_fb_bad,
  input  logic             load_over_max,
  input  logic             comm_fault,
  input  logic             system_fault,
  output logic [NB-1:0]    brake_release_cmd,
  output logic             drive_current_req,
  output logic             irq
);

  // bus side state
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic             sup_en_r;
  logic             cfg_ok_r;
  logic [NB-1:0]    att_r;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] ist_nxt;
  logic             irq_r;

  // sequencer state
  bts_state_t       st_r;
  bts_state_t       st_nxt;
  bts_phase_t       ph_r;
  bts_phase_t       ph_nxt;
  logic             sel_r;
  logic             sel_nxt;
  logic [15:0]      cnt_r;
  logic [15:0]      cnt_nxt;
  logic [7:0]       err_r;
  logic [7:0]       err_nxt;
  logic [NB-1:0]    fail_r;
  logic [NB-1:0]    fail_nxt;
  logic [NB-1:0]    rel_r;
  logic [NB-1:0]    rel_nxt;
  logic             cur_r;
  logic             cur_nxt;

  // supervision and status
  logic             sup_r;
  logic             sup_nxt;
  logic             ack_r;
  logic             ack_nxt;
  logic [NB-1:0]    brk_cmd_r;
  logic [NAR-1:0]   ar_act_r;
  logic [2*NAR-1:0] ar_st_r;
  logic [NAR-1:0]   ar_flt;

  // read words
  logic [31:0]      rd_ctrl;
  logic [31:0]      rd_status;
  logic [31:0]      rd_accel;

  // address decode
  wire a_ctrl   = (paddr == OFF_CTRL);
  wire a_cmd    = (paddr == OFF_CMD);
  wire a_status = (paddr == OFF_STATUS);
  wire a_accel  = (paddr == OFF_ACCEL);
  wire a_istat  = (paddr == OFF_ISTAT);
  wire a_imask  = (paddr == OFF_IMASK);
  wire a_hit    = a_ctrl | a_cmd | a_status | a_accel | a_istat | a_imask;

  // bus phases; a write lands at the access edge only
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_r & pwrite & a_hit;

  // commands, trigger only honoured when configured and idle
  wire cmd_wr  = wr_en & a_cmd;
  wire go      = cmd_wr & pwdata[CMD_TRIG] & cfg_ok_r & (st_r == BTS_IDLE);
  wire abort   = cmd_wr & pwdata[CMD_ABORT];
  wire ack_wr  = cmd_wr & pwdata[CMD_ACK];
  wire w1c_wr  = wr_en & a_istat;

  // read selection
  wire [31:0] rd_mux = a_ctrl   ? rd_ctrl :
                       a_status ? rd_status :
                       a_accel  ? rd_accel :
                       a_istat  ? {{(32-IRQ_W){1'b0}}, ist_r} :
                       a_imask  ? {{(32-IRQ_W){1'b0}}, mask_r} :
                       32'h0000_0000;

  // sequencer helpers
  wire running  = (st_r == BTS_STARTING) | (st_r == BTS_STARTED) | (st_r == BTS_TESTING);
  wire test_on  = (st_r == BTS_STARTED) | (st_r == BTS_TESTING);
  wire tmo      = (cnt_r == 16'(TIMEOUT_CYC - 1));
  wire hold_end = (cnt_r == 16'(HOLD_CYC - 1));
  wire first    = ~att_r[0];
  wire more     = (sel_r == 1'b0) & att_r[NB-1];
  wire all_rel  = ((brake_released_fb & att_r) == att_r);

  // events feeding the interrupt status
  wire enter_stop = (st_r != BTS_STOPPING) & (st_nxt == BTS_STOPPING);
  wire brk_flt    = enter_stop & ((err_nxt == ERR_APPLY) | (err_nxt == ERR_RELEASE) |
                    (err_nxt == ERR_MOTION) | (err_nxt == ERR_CUR_FB) |
                    (err_nxt == ERR_LOAD));
  wire ev_done    = (st_r == BTS_STOPPING);
  wire ev_err     = (st_r == BTS_STOPPING) & (err_r != ERR_NONE);
  wire ev_sup     = (sup_nxt != sup_r);
  wire ev_ar      = |ar_flt;
  wire [IRQ_W-1:0] ev = {ev_ar, ev_sup, ev_err, ev_done};

  // fault entry detection per accel range instance
  genvar gi;
  generate
    for (gi = 0; gi < NAR; gi++) begin : g_ar
      assign ar_flt[gi] = (ar_state_in[2*gi +: 2] == AR_FAULT) &
                          (ar_st_r[2*gi +: 2] != AR_FAULT);
    end
  endgenerate

  // assemble readable words
  always_comb begin
    rd_ctrl = 32'h0000_0000;
    rd_ctrl[CTL_SUP_EN] = sup_en_r;
    rd_ctrl[CTL_CFG_OK] = cfg_ok_r;
    rd_ctrl[CTL_ATT_LSB +: NB] = att_r;
    rd_status = 32'h0000_0000;
    rd_status[STS_SUP] = sup_r;
    rd_status[STS_ACK] = ack_r;
    rd_status[STS_PROG_LSB +: 3] = st_r;
    rd_status[STS_ERR_LSB +: 8] = err_r;
    rd_status[STS_FAIL_LSB +: NB] = fail_r;
    rd_accel = 32'h0000_0000;
    rd_accel[AR_ACT_LSB +: NAR] = ar_act_r;
    rd_accel[AR_ST_LSB +: 2*NAR] = ar_st_r;
  end

  // apb answer, no wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~a_hit;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // control and mask registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_en_r <= CTRL_RST[CTL_SUP_EN];
      cfg_ok_r <= CTRL_RST[CTL_CFG_OK];
      att_r    <= CTRL_RST[CTL_ATT_LSB +: NB];
      mask_r   <= MASK_RST;
    end else begin
      if (wr_en & a_ctrl) begin
        sup_en_r <= pwdata[CTL_SUP_EN];
        cfg_ok_r <= pwdata[CTL_CFG_OK];
        att_r    <= pwdata[CTL_ATT_LSB +: NB];
      end
      if (wr_en & a_imask) begin
        mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // sticky status, a new event wins over the clear
  assign ist_nxt = (ist_r & ~(w1c_wr ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | ev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= {IRQ_W{1'b0}};
      irq_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      irq_r <= |(ist_nxt & mask_r);
    end
  end

  // brake supervision engages at standstill, ends with the stop condition
  always_comb begin
    sup_nxt = sup_r;
    if (!sup_r) begin
      if (sup_en_r & stop_func_active & axis_standstill) begin
        sup_nxt = 1'b1;
      end
    end else if (!stop_func_active) begin
      sup_nxt = 1'b0;
    end
  end

  // acknowledge state, a brake fault wins over a software ack
  assign ack_nxt = brk_flt ? 1'b0 : (ack_wr ? 1'b1 : ack_r);

  // brake test sequencer
  always_comb begin
    st_nxt   = st_r;
    ph_nxt   = ph_r;
    sel_nxt  = sel_r;
    cnt_nxt  = cnt_r + 16'h0001;
    err_nxt  = err_r;
    fail_nxt = fail_r;
    rel_nxt  = rel_r;
    cur_nxt  = cur_r;
    case (st_r)
      BTS_IDLE: begin
        cnt_nxt = 16'h0000;
        if (go) begin
          st_nxt   = BTS_STARTING;
          err_nxt  = ERR_NONE;
          fail_nxt = {NB{1'b0}};
        end
      end
      BTS_STARTING: begin
        cnt_nxt = 16'h0000;
        if (!axis_enabled || !axis_standstill) begin
          err_nxt = ERR_START;
          st_nxt  = BTS_STOPPING;
        end else if (!all_rel) begin
          err_nxt = ERR_NOT_REL;
          st_nxt  = BTS_STOPPING;
        end else if (att_r == {NB{1'b0}}) begin
          st_nxt = BTS_STOPPING;
        end else begin
          st_nxt  = BTS_STARTED;
          cur_nxt = 1'b1;
          rel_nxt = att_r;
        end
      end
      BTS_STARTED: begin
        if (drive_current_ok) begin
          st_nxt  = BTS_TESTING;
          ph_nxt  = BTS_PH_APPLY;
          sel_nxt = first;
          cnt_nxt = 16'h0000;
        end else if (tmo) begin
          err_nxt = ERR_CURRENT;
          st_nxt  = BTS_STOPPING;
        end
      end
      BTS_TESTING: begin
        case (ph_r)
          BTS_PH_APPLY: begin
            rel_nxt[sel_r] = 1'b0;
            if (!brake_released_fb[sel_r]) begin
              ph_nxt  = BTS_PH_HOLD;
              cnt_nxt = 16'h0000;
            end else if (tmo) begin
              err_nxt         = ERR_APPLY;
              fail_nxt[sel_r] = 1'b1;
              st_nxt          = BTS_STOPPING;
            end
          end
          BTS_PH_HOLD: begin
            if (motion_limit_hit) begin
              err_nxt         = ERR_MOTION;
              fail_nxt[sel_r] = 1'b1;
              st_nxt          = BTS_STOPPING;
            end else if (current_fb_bad) begin
              err_nxt         = ERR_CUR_FB;
              fail_nxt[sel_r] = 1'b1;
              st_nxt          = BTS_STOPPING;
            end else if (load_over_max) begin
              err_nxt = ERR_LOAD;
              st_nxt  = BTS_STOPPING;
            end else if (hold_end) begin
              ph_nxt         = BTS_PH_RELEASE;
              rel_nxt[sel_r] = 1'b1;
              cnt_nxt        = 16'h0000;
            end
          end
          BTS_PH_RELEASE: begin
            if (brake_released_fb[sel_r]) begin
              cnt_nxt = 16'h0000;
              if (more) begin
                sel_nxt = 1'b1;
                ph_nxt  = BTS_PH_APPLY;
              end else begin
                st_nxt = BTS_STOPPING;
              end
            end else if (tmo) begin
              err_nxt         = ERR_RELEASE;
              fail_nxt[sel_r] = 1'b1;
              st_nxt          = BTS_STOPPING;
            end
          end
          default: begin
            err_nxt = ERR_UNKNOWN;
            st_nxt  = BTS_STOPPING;
          end
        endcase
      end
      BTS_STOPPING: begin
        cur_nxt = 1'b0;
        rel_nxt = att_r;
        cnt_nxt = 16'h0000;
        st_nxt  = BTS_IDLE;
      end
      default: begin
        err_nxt = ERR_UNKNOWN;
        st_nxt  = BTS_STOPPING;
      end
    endcase
    // overriding faults while the test runs
    if (running) begin
      if (system_fault) begin
        err_nxt = ERR_SYSTEM;
        st_nxt  = BTS_STOPPING;
      end else if (comm_fault) begin
        err_nxt = ERR_COMM;
        st_nxt  = BTS_STOPPING;
      end else if (abort) begin
        err_nxt = ERR_USER;
        st_nxt  = BTS_STOPPING;
      end else if (st_r == BTS_TESTING && ph_r == BTS_PH_HOLD && tmo) begin
        err_nxt = ERR_TIMEOUT;
        st_nxt  = BTS_STOPPING;
      end
    end
  end

  // sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r   <= BTS_IDLE;
      ph_r   <= BTS_PH_APPLY;
      sel_r  <= 1'b0;
      cnt_r  <= 16'h0000;
      err_r  <= ERR_NONE;
      fail_r <= {NB{1'b0}};
      rel_r  <= {NB{1'b0}};
      cur_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ph_r   <= ph_nxt;
      sel_r  <= sel_nxt;
      cnt_r  <= cnt_nxt;
      err_r  <= err_nxt;
      fail_r <= fail_nxt;
      rel_r  <= rel_nxt;
      cur_r  <= cur_nxt;
    end
  end

  // supervision, ack, brake outputs and sampled supervisor status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_r     <= 1'b0;
      ack_r     <= 1'b1;
      brk_cmd_r <= {NB{1'b0}};
      ar_act_r  <= {NAR{1'b0}};
      ar_st_r   <= {(2*NAR){1'b0}};
    end else begin
      sup_r     <= sup_nxt;
      ack_r     <= ack_nxt;
      brk_cmd_r <= sup_nxt ? {NB{1'b0}} :
                   (test_on ? rel_nxt : brake_release_req);
      ar_act_r  <= ar_active_in;
      ar_st_r   <= ar_state_in;
    end
  end

  // outputs, all from flip-flops
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign brake_release_cmd = brk_cmd_r;
  assign drive_current_req = cur_r;
  assign irq               = irq_r;

endmodule

// ---- bts_props.sv ----
// Purpose: port assertions of the brake test status block
// Assumes: bound into every bts_top instance
// Notes:   sees the top ports only
`timescale 1ns/1ps
module bts_props import bts_pkg::*; #(
  parameter int NAR         = 3,
  parameter int NB          = 2,
  parameter int TIMEOUT_CYC = STEP_TIMEOUT_CYC
) (
  input logic          clk,
  input logic          rst,
  input logic [7:0]    paddr,
  input logic          psel,
  input logic          penable,
  input logic [31:0]   prdata,
  input logic          pready,
  input logic          pslverr,
  input logic          axis_enabled,
  input logic          axis_standstill,
  input logic [NB-1:0] brake_release_req,
  input logic          drive_current_ok,
  input logic          comm_fault,
  input logic          system_fault,
  input logic [NB-1:0] brake_release_cmd,
  input logic          drive_current_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int wait_r;

  // cycles the current is asked for and not yet granted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 0;
    end else begin
      wait_r <= (drive_current_req && !drive_current_ok) ? wait_r + 1 : 0;
    end
  end

  // apb setup and its single answer cycle
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence

  // bus handshake
  apb_answer_a: assert property (apb_setup |=> apb_answer)
    else $error("pready not one cycle after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
    else $error("unmapped access not flagged");
  rdata_hold_a: assert property (pready |=> $stable(prdata))
    else $error("read data moved after access");
  // brake test sequencing
  start_gate_a: assert property ($rose(drive_current_req) |->
    $past(axis_enabled && axis_standstill))
    else $error("test started without enabled standstill axis");
  current_wait_a: assert property (wait_r <= TIMEOUT_CYC + 2)
    else $error("current wait not cut off");
  sys_stop_a: assert property (drive_current_req && system_fault |->
    ##[1:3] !drive_current_req)
    else $error("system fault did not stop the test");
  comm_stop_a: assert property (drive_current_req && comm_fault |=>
    ##[0:2] !drive_current_req)
    else $error("comm fault did not stop the test");
  release_guard_a: assert property (!drive_current_req [*3] |=>
    (brake_release_cmd & ~$past(brake_release_req)) == '0)
    else $error("brake released without request");
endmodule

bind bts_top bts_props #(.NAR(NAR), .NB(NB), .TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk, .rst, .paddr, .psel, .penable, .prdata, .pready, .pslverr, .axis_enabled,
  .axis_standstill, .brake_release_req, .drive_current_ok, .comm_fault,
  .system_fault, .brake_release_cmd, .drive_current_req
);

// ---- bts_brake_model.sv ----
// Purpose: behavioural holding brakes and drive power stage
// Assumes: feedback follows the release command after a lag
// Notes:   slow lengthens the lag, freeze sticks the feedback
`timescale 1ns/1ps
module bts_brake_model (
  input  logic       clk,
  input  logic       rst,
  input  logic [1:0] brake_release_cmd,
  input  logic       drive_current_req,
  input  logic       slow,
  input  logic       freeze,
  input  logic       no_cur,
  output logic [1:0] brake_released_fb,
  output logic       drive_current_ok
);
  logic [1:0] lag1_r;
  logic [1:0] lag2_r;

  // brake travel lag and current stage answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lag1_r            <= 2'h0;
      lag2_r            <= 2'h0;
      brake_released_fb <= 2'h0;
      drive_current_ok  <= 1'b0;
    end else begin
      lag1_r <= brake_release_cmd;
      lag2_r <= lag1_r;
      if (!freeze) begin
        brake_released_fb <= slow ? lag2_r : lag1_r;
      end
      drive_current_ok <= drive_current_req && !no_cur;
    end
  end
endmodule

// ---- test_safe_brake_test_status.sv ----
// Purpose: self-checking bench of the brake test status block
// Assumes: step timeouts of 2500 cycles, longer than the brake hold time
// Notes:   registers over apb, brakes from bts_brake_model
`timescale 1ns/1ps
module test_safe_brake_test_status import bts_pkg::*; ();
  localparam int TO = 2500;
  logic        clk;
  logic        rst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ar_active_in;
  logic [5:0]  ar_state_in;
  logic        axis_enabled;
  logic        axis_standstill;
  logic        stop_func_active;
  logic [1:0]  brake_release_req;
  logic [1:0]  brake_released_fb;
  logic        drive_current_ok;
  logic        motion_limit_hit;
  logic        current_fb_bad;
  logic        load_over_max;
  logic        comm_fault;
  logic        system_fault;
  logic [1:0]  brake_release_cmd;
  logic        drive_current_req;
  logic        irq;
  logic        slow;
  logic        freeze;
  logic        no_cur;
  logic [1:0]  applied;
  logic [31:0] rv;
  int          miscompares;
  int          n_checks;

  bts_top #(.TIMEOUT_CYC(TO)) dut (
    .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .ar_active_in, .ar_state_in, .axis_enabled, .axis_standstill,
    .stop_func_active, .brake_release_req, .brake_released_fb, .drive_current_ok,
    .motion_limit_hit, .current_fb_bad, .load_over_max, .comm_fault, .system_fault,
    .brake_release_cmd, .drive_current_req, .irq
  );
  bts_brake_model brakes (
    .clk, .rst, .brake_release_cmd, .drive_current_req, .slow, .freeze, .no_cur,
    .brake_released_fb, .drive_current_ok
  );

  // clock and record of brakes applied under test current
  always #25 clk = ~clk;
  always @(posedge clk) if (drive_current_req) applied <= applied | ~brake_release_cmd;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer, read data left in rv
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      finish_test;
    end
    rv = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask

  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, e);
  endtask

  // poll status until the test reaches a progress code
  task automatic wait_prog(input logic [2:0] p);
    int n;
    n = 0;
    do begin
      rd(OFF_STATUS);
      n++;
    end while (rv[STS_PROG_LSB+:3] !== p && n < 3000);
    chk("progress", {29'h0, p}, {29'h0, rv[STS_PROG_LSB+:3]});
    if (rv[STS_PROG_LSB+:3] !== p) finish_test;
  endtask

  task automatic wait_err(input logic [7:0] ex);
    wait_prog(3'h0);
    chk("error code", {24'h0, ex}, {24'h0, rv[STS_ERR_LSB+:8]});
  endtask

  task automatic t_reset;
    logic e;
    rd(OFF_STATUS);
    chk("status", 32'h2, rv);
    rd(OFF_CTRL);
    chk("ctrl", CTRL_RST, rv);
    apb(1'b0, 8'h18, 32'h0, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(OFF_STATUS, 32'hffff_ffff);
    rd(OFF_STATUS);
    chk("status ro", 32'h2, rv);
    $display("test reset done");
  endtask

  task automatic t_accel;
    ar_active_in <= 3'b101;
    ar_state_in  <= 6'b10_01_00;
    rd(OFF_ACCEL);
    chk("accel", 32'h0024_0005, rv);
    $display("test accel done");
  endtask

  task automatic t_gate;
    wr(OFF_CTRL, 32'h30);
    wr(OFF_CMD, 32'h1);
    rd(OFF_STATUS);
    chk("ignored start", 32'h2, rv);
    wr(OFF_CTRL, 32'h32);
    axis_enabled <= 1'b0;
    wr(OFF_CMD, 32'h1);
    wait_err(ERR_START);
    axis_enabled      <= 1'b1;
    brake_release_req <= 2'b01;
    repeat (4) @(posedge clk);
    wr(OFF_CMD, 32'h1);
    wait_err(ERR_NOT_REL);
    brake_release_req <= 2'b11;
    $display("test gate done");
  endtask

  task automatic t_pass;
    // clear all but the accel fault bit, which stays masked
    wr(OFF_ISTAT, 32'h7);
    wr(OFF_IMASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(OFF_CMD, 32'h1);
    wait_prog(3'h3);
    chk("current on", 32'h1, {31'h0, drive_current_req});
    wait_err(ERR_NONE);
    chk("current off", 32'h0, {31'h0, drive_current_req});
    chk("brakes tested", 32'h3, {30'h0, applied});
    chk("irq", 32'h1, {31'h0, irq});
    rd(OFF_ISTAT);
    chk("istat", 32'h9, rv);
    wr(OFF_ISTAT, 32'hf);
    rd(OFF_ISTAT);
    chk("istat clear", 32'h0, rv);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test pass done");
  endtask

  task automatic t_faults;
    logic [7:0] code [5] = '{ERR_MOTION, ERR_CUR_FB, ERR_LOAD, ERR_COMM, ERR_SYSTEM};
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CMD, 32'h1);
      wait_prog(3'h3);
      repeat (10) @(posedge clk);
      {motion_limit_hit, current_fb_bad, load_over_max, comm_fault, system_fault} <= 5'h10 >> i;
      wait_err(code[i]);
      {motion_limit_hit, current_fb_bad, load_over_max, comm_fault, system_fault} <= 5'h0;
      chk("ack", {31'h0, i > 2}, {31'h0, rv[STS_ACK]});
      wr(OFF_CMD, 32'h4);
    end
    wr(OFF_CMD, 32'h1);
    wait_prog(3'h3);
    wr(OFF_CMD, 32'h2);
    wait_err(ERR_USER);
    no_cur <= 1'b1;
    wr(OFF_CMD, 32'h1);
    wait_err(ERR_CURRENT);
    no_cur <= 1'b0;
    slow   <= 1'b1;
    freeze <= 1'b1;
    wr(OFF_CMD, 32'h1);
    wait_err(ERR_APPLY);
    chk("failed brake", 32'h1, {30'h0, rv[STS_FAIL_LSB+:2]});
    freeze <= 1'b0;
    wr(OFF_CMD, 32'h4);
    rd(OFF_STATUS);
    chk("ack set", 32'h1, {31'h0, rv[STS_ACK]});
    wr(OFF_CMD, 32'h1);
    wait_prog(3'h3);
    repeat (10) @(posedge clk);
    freeze <= 1'b1;
    wait_err(ERR_RELEASE);
    freeze <= 1'b0;
    $display("test faults done");
  endtask

  task automatic t_sup;
    wr(OFF_CTRL, 32'h33);
    axis_standstill  <= 1'b0;
    stop_func_active <= 1'b1;
    rd(OFF_STATUS);
    chk("sup moving", 32'h0, {31'h0, rv[STS_SUP]});
    axis_standstill <= 1'b1;
    rd(OFF_STATUS);
    chk("sup on", 32'h1, {31'h0, rv[STS_SUP]});
    chk("release held", 32'h0, {30'h0, brake_release_cmd});
    stop_func_active <= 1'b0;
    rd(OFF_STATUS);
    chk("sup off", 32'h0, {31'h0, rv[STS_SUP]});
    chk("release back", 32'h3, {30'h0, brake_release_cmd});
    $display("test supervision done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {ar_active_in, ar_state_in, stop_func_active} = '0;
    {motion_limit_hit, current_fb_bad, load_over_max, comm_fault, system_fault} = '0;
    {slow, freeze, no_cur, applied} = '0;
    axis_enabled = 1'b1;
    axis_standstill = 1'b1;
    brake_release_req = 2'b11;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_accel;
    t_gate;
    t_pass;
    t_faults;
    t_sup;
    finish_test;
  end

  // watchdog against a hang
  initial begin
    #2_000_000;
    miscompares++;
    $display("ERROR watchdog expected end seen hang");
    finish_test;
  end
endmodule
